// ==== ast_tx.sv ====
// Asynchronous serial transmitter with bit rate divider and register port
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ast_params.svh"

module ast_tx (
  input  wire logic       mclk,         // System clock, 100 MHz
  input  wire logic       reset,        // Synchronous reset, active high
  input  wire logic [7:0] addr,         // Register address
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output logic      [7:0] rdata,        // Read data, cycle after strobe
  input  wire logic       sleep,        // Low-power sleep request (pin)
  output logic            serial_out,   // Serial line level
  output logic            serial_oe,    // Serial line drive enable
  output logic            tx_irq        // Transmit interrupt request
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] tsc_r;                    // Transmit status and control
  logic [7:0] divisor_r;                // Bit rate divisor
  logic [7:0] hold_r;                   // Transmit holding buffer
  logic       hold_full_r;              // Holding buffer has data
  logic       empty_flag_r;             // Transmit buffer empty flag
  logic       tx_int_en_r;              // Transmit interrupt enable
  logic       port_en_r;                // Serial port enable
  logic       sleep_s1_r;               // Sleep synchroniser stage one
  logic       sleep_s2_r;               // Sleep synchroniser stage two
  logic [7:0] div_cnt_r;                // Divider counter
  logic [5:0] ovs_cnt_r;                // Oversample counter
  logic [8:0] shifter_r;                // Transmit shifter, not mapped
  logic [3:0] bit_idx_r;                // Data bit index
  logic       ninth_r;                  // Frame carries ninth bit
  ast_pkg::ast_phase_t phase_r;         // Transmitter phase
  logic       tx_en_prev_r;             // Transmit enable last cycle
  logic       serial_out_r;             // Line level register

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Address match for a register strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_tsc;                         // Write to status/control
  logic wr_hold;                        // Write to holding buffer
  logic wr_div;                         // Write to divisor
  logic active;                         // Asynchronous mode running
  logic tx_en;                          // Transmit enable bit
  logic tick;                           // Divider overflow
  logic bit_end;                        // Last tick of a bit time
  logic shifter_empty;                  // Shifter holds nothing
  logic load;                           // Move buffer into shifter
  logic [5:0] ovs_last;                 // Ticks per bit minus one

  assign wr_tsc   = wr && hit(addr, `AST_OFF_TSC);
  assign wr_hold  = wr && hit(addr, `AST_OFF_HOLD);
  assign wr_div   = wr && hit(addr, `AST_OFF_DIVISOR);
  assign tx_en    = tsc_r[`AST_TSC_TX_EN];
  // Clocked mode clear, port on, not asleep
  assign active   = port_en_r && !tsc_r[`AST_TSC_CLOCKED] && !sleep_s2_r;
  assign shifter_empty = (phase_r == ast_pkg::AST_IDLE);
  assign ovs_last = tsc_r[`AST_TSC_HIGH_SPEED] ? `AST_OVS_HIGH_LAST : `AST_OVS_LOW_LAST;
  assign tick     = active && (div_cnt_r == divisor_r);
  assign bit_end  = tick && (ovs_cnt_r == ovs_last);
  // Load from buffer only when the shifter is empty
  assign load     = active && tx_en && hold_full_r && shifter_empty;

  // ----------------------------------------------------------------
  // Sleep synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      tsc_r       <= `AST_TSC_RESET;
      divisor_r   <= `AST_BYTE_ZERO;
      tx_int_en_r <= 1'b0;
      port_en_r   <= 1'b0;
    end else begin
      // Shifter empty bit is read-only, bit 3 unimplemented
      if (wr_tsc) begin
        tsc_r <= {wdata[7:4], 1'b0, wdata[`AST_TSC_HIGH_SPEED], 1'b0, wdata[`AST_TSC_NINTH_VAL]};
      end
      if (wr_div) begin
        divisor_r <= wdata;
      end
      if (wr && hit(addr, `AST_OFF_ENABLES)) begin
        tx_int_en_r <= wdata[`AST_FLAG_TX_EMPTY];
      end
      if (wr && hit(addr, `AST_OFF_SERIAL_CTRL)) begin
        port_en_r <= wdata[`AST_SCTRL_PORT_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || wr_div || !active) begin
      div_cnt_r <= `AST_BYTE_ZERO;
    end else if (tick) begin
      div_cnt_r <= `AST_BYTE_ZERO;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer and empty flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_r       <= `AST_BYTE_ZERO;
      hold_full_r  <= 1'b0;
      empty_flag_r <= 1'b0;
    end else begin
      if (wr_hold) begin
        // New data clears the flag; software cannot clear it otherwise
        hold_r       <= wdata;
        hold_full_r  <= 1'b1;
        empty_flag_r <= 1'b0;
      end else if (load) begin
        // Move empties the buffer in one cycle
        hold_full_r  <= 1'b0;
        empty_flag_r <= 1'b1;
      end else if (tx_en && !tx_en_prev_r) begin
        empty_flag_r <= !hold_full_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter and framing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || !tx_en) begin
      // Abort resets the transmitter
      phase_r      <= ast_pkg::AST_IDLE;
      shifter_r    <= 9'h000;
      bit_idx_r    <= 4'h0;
      ninth_r      <= 1'b0;
      ovs_cnt_r    <= 6'h00;
      serial_out_r <= 1'b1;
    end else if (load) begin
      // Ninth bit captured at load time, no parity generated
      shifter_r <= {tsc_r[`AST_TSC_NINTH_VAL], hold_r};
      ninth_r   <= tsc_r[`AST_TSC_NINTH_SEL];
      bit_idx_r <= 4'h0;
      ovs_cnt_r <= 6'h00;
      phase_r   <= ast_pkg::AST_START;
    end else if (tick) begin
      ovs_cnt_r <= bit_end ? 6'h00 : ovs_cnt_r + 6'h01;
      unique case (phase_r)
        ast_pkg::AST_IDLE: begin
          serial_out_r <= 1'b1;
        end
        ast_pkg::AST_START: begin
          // Start bit waits for first shift clock
          serial_out_r <= 1'b0;
          if (bit_end) begin
            phase_r <= ast_pkg::AST_DATA;
          end
        end
        ast_pkg::AST_DATA: begin
          serial_out_r <= shifter_r[0];
          if (bit_end) begin
            shifter_r <= {1'b0, shifter_r[8:1]};
            bit_idx_r <= bit_idx_r + 4'h1;
            if (bit_idx_r == (ninth_r ? `AST_NINTH_LAST : `AST_DATA_LAST)) begin
              phase_r <= ast_pkg::AST_STOP;
            end
          end
        end
        ast_pkg::AST_STOP: begin
          serial_out_r <= 1'b1;
          if (bit_end) begin
            phase_r <= ast_pkg::AST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable edge tracker
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_en_prev_r <= 1'b0;
    end else begin
      tx_en_prev_r <= tx_en;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= `AST_BYTE_ZERO;
    end else if (rd) begin
      // Shifter has no address; unmapped reads give zero
      if (hit(addr, `AST_OFF_TSC)) begin
        rdata <= {tsc_r[7:2], shifter_empty, tsc_r[0]};
      end else if (hit(addr, `AST_OFF_DIVISOR)) begin
        rdata <= divisor_r;
      end else if (hit(addr, `AST_OFF_HOLD)) begin
        rdata <= hold_r;
      end else if (hit(addr, `AST_OFF_FLAGS)) begin
        rdata <= {3'h0, empty_flag_r, 4'h0};
      end else if (hit(addr, `AST_OFF_ENABLES)) begin
        rdata <= {3'h0, tx_int_en_r, 4'h0};
      end else if (hit(addr, `AST_OFF_SERIAL_CTRL)) begin
        rdata <= {port_en_r, 7'h00};
      end else begin
        rdata <= `AST_BYTE_ZERO;
      end
    end else begin
      rdata <= `AST_BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_out = serial_out_r;
  assign serial_oe  = tx_en && port_en_r;
  assign tx_irq     = empty_flag_r && tx_int_en_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_load;
    load && !wr_hold;
  endsequence

  property p_load_empties;
    @(posedge mclk) disable iff (reset) s_load |=> (!hold_full_r && empty_flag_r);
  endproperty
  a_load_empties: assert property (p_load_empties) else $error("buffer not emptied by load");

  property p_write_clears;
    @(posedge mclk) disable iff (reset) wr_hold |=> !empty_flag_r && hold_full_r;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("write left flag set");

  property p_irq;
    @(posedge mclk) disable iff (reset) !tx_int_en_r |-> !tx_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enable");

  property p_abort;
    @(posedge mclk) disable iff (reset) $fell(tx_en) |-> !serial_oe ##1 (phase_r == ast_pkg::AST_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset");

  property p_div_clear;
    @(posedge mclk) disable iff (reset) wr_div |=> (div_cnt_r == 8'h00);
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared");

  property p_enable_sets;
    @(posedge mclk) disable iff (reset) (tx_en && !tx_en_prev_r && !hold_full_r && !wr_hold) |=> empty_flag_r;
  endproperty
  a_enable_sets: assert property (p_enable_sets) else $error("enable left flag clear");

  property p_idle_high;
    @(posedge mclk) disable iff (reset) (phase_r == ast_pkg::AST_IDLE) ##1 (phase_r == ast_pkg::AST_IDLE) |-> serial_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line low");

  property p_sleep_halts;
    @(posedge mclk) disable iff (reset) sleep_s2_r |-> !tick;
  endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("divider ran in sleep");

  property p_no_reload_busy;
    @(posedge mclk) disable iff (reset) (phase_r != ast_pkg::AST_IDLE) |-> !load;
  endproperty
  a_no_reload_busy: assert property (p_no_reload_busy) else $error("shifter reloaded early");

  property p_start_low;
    @(posedge mclk) disable iff (reset) (phase_r == ast_pkg::AST_START && tick && tx_en) |=> !serial_out;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  // ----------------------------------------------------------------
  // Framing and mode assertions
  // ----------------------------------------------------------------
  // Shift clock in the stop phase of a running frame
  sequence s_stop_tick;
    phase_r == ast_pkg::AST_STOP && tick && tx_en;
  endsequence

  // Shift clock in the data phase of a running frame
  sequence s_data_tick;
    phase_r == ast_pkg::AST_DATA && tick && tx_en;
  endsequence

  // Stop bit drives the line high
  property p_stop_high;
    @(posedge mclk) disable iff (reset) s_stop_tick |=> serial_out;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  // Data bits leave from the low end of the shifter
  property p_data_lsb;
    @(posedge mclk) disable iff (reset) s_data_tick |=> (serial_out == $past(shifter_r[0]));
  endproperty
  a_data_lsb: assert property (p_data_lsb) else $error("data bit out of order");

  // Stop phase lasts until its last shift clock, so no early reload
  property p_stop_holds;
    @(posedge mclk) disable iff (reset)
      (phase_r == ast_pkg::AST_STOP && tx_en && !bit_end) |=> (phase_r == ast_pkg::AST_STOP);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stop bit cut short");

  // Clocked mode keeps the divider silent
  property p_clocked_halts;
    @(posedge mclk) disable iff (reset) tsc_r[`AST_TSC_CLOCKED] |-> !tick;
  endproperty
  a_clocked_halts: assert property (p_clocked_halts) else $error("divider ran in clocked mode");

  // Pin floats whenever transmit enable is clear
  property p_oe_off;
    @(posedge mclk) disable iff (reset) !tx_en |-> !serial_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("line driven while disabled");

  // Ninth bit value is captured at load time
  property p_ninth_capture;
    @(posedge mclk) disable iff (reset) load |=> (shifter_r[8] == $past(tsc_r[`AST_TSC_NINTH_VAL]));
  endproperty
  a_ninth_capture: assert property (p_ninth_capture) else $error("ninth bit not captured");

  // Enabled interrupt follows the empty flag set by a load
  property p_irq_after_load;
    @(posedge mclk) disable iff (reset) s_load ##1 tx_int_en_r |-> tx_irq;
  endproperty
  a_irq_after_load: assert property (p_irq_after_load) else $error("interrupt missing after load");

endmodule // ast_tx
`default_nettype wire

// ==== ast_params.svh ====
// Register offsets, field positions, reset values and timing constants for the serial transmitter
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte-wide registers on a plain port)
// ----------------------------------------------------------------
`define AST_ADDR_W            8
`define AST_OFF_FLAGS         8'h0C
`define AST_OFF_SERIAL_CTRL   8'h18
`define AST_OFF_HOLD          8'h19
`define AST_OFF_ENABLES       8'h8C
`define AST_OFF_TSC           8'h98
`define AST_OFF_DIVISOR       8'h99

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AST_TSC_NINTH_VAL     0
`define AST_TSC_SHIFT_EMPTY   1
`define AST_TSC_HIGH_SPEED    2
`define AST_TSC_CLOCKED       4
`define AST_TSC_TX_EN         5
`define AST_TSC_NINTH_SEL     6
`define AST_TSC_CLK_SRC       7
`define AST_FLAG_TX_EMPTY     4
`define AST_SCTRL_PORT_EN     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AST_TSC_RESET         8'h02
`define AST_BYTE_ZERO         8'h00

// ----------------------------------------------------------------
// Oversampling ticks per bit and last data bit index (minus one)
// ----------------------------------------------------------------
`define AST_OVS_HIGH_LAST     6'h0F
`define AST_OVS_LOW_LAST      6'h3F
`define AST_DATA_LAST         4'h7
`define AST_NINTH_LAST        4'h8

`endif

// ==== ast_pkg.sv ====
// Types shared by the serial transmitter
package ast_pkg;
  // Transmitter phase
  typedef enum logic [1:0] {
    AST_IDLE  = 2'b00,
    AST_START = 2'b01,
    AST_DATA  = 2'b10,
    AST_STOP  = 2'b11
  } ast_phase_t;
endpackage

// ==== ast_rx_model.sv ====
// Remote asynchronous receiver model that decodes frames seen on the serial line
`timescale 1ns/10ps
`default_nettype none
module ast_rx_model (
  input  wire logic        mclk,        // System clock
  input  wire logic        serial_out,  // Line level from the transmitter
  input  wire logic        serial_oe,   // Line drive enable
  input  wire logic        nine,        // Expect a ninth data bit
  input  wire logic [15:0] bit_cyc,     // Clock cycles per bit
  output logic             frm_vld,     // One-cycle pulse per whole frame
  output logic      [9:0]  frm          // Stop bit, ninth bit, eight data bits
);
  // ----------------------------------------
  // Frame decoder, samples mid-bit on the falling clock edge
  // ----------------------------------------
  logic [9:0] sh;  // Bits in line order
  logic       ok;  // Line stayed driven for the whole frame
  int         i;   // Bit index
  int         n;   // Bits after the start bit
  initial begin
    frm_vld = 1'b0;
    frm = 10'h000;
    forever begin
      @(negedge mclk);
      frm_vld = 1'b0;
      // Start bit: low while driven
      if (serial_oe && !serial_out) begin
        sh = 10'h000;
        ok = 1'b1;
        n = nine ? 10 : 9;
        repeat (bit_cyc / 2) @(negedge mclk);
        for (i = 0; i < n; i++) begin
          repeat (bit_cyc) @(negedge mclk);
          sh[i] = serial_out;  // First data bit is the LSB
          ok = ok & serial_oe;
        end
        // Aborted frames are dropped, whole ones reported
        if (ok) begin
          frm = nine ? sh : {sh[8], 1'b0, sh[7:0]};
          frm_vld = 1'b1;
        end
      end
    end
  end
endmodule // ast_rx_model
`default_nettype wire

// ==== ast_tx_test.sv ====
// Self-checking testbench for the asynchronous serial transmitter
`timescale 1ns/10ps
`default_nettype none
`include "ast_params.svh"
module ast_tx_test;
  logic        mclk, reset, wr, rd, sleep, serial_out, serial_oe, tx_irq, nine, frm_vld, rd_q;
  logic [7:0]  addr, wdata, rdata, d, div;
  logic [15:0] bit_cyc;      // Cycles per bit for the receiver model
  logic [9:0]  frm;          // Frame from the receiver model
  logic [7:0]  exp_rd[$];    // Expected read data
  logic [9:0]  exp_rx[$];    // Expected frames
  int          error_cnt, total_checks, k;

  ast_tx uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sleep(sleep), .serial_out(serial_out), .serial_oe(serial_oe), .tx_irq(tx_irq));
  ast_rx_model rx (.mclk(mclk), .serial_out(serial_out), .serial_oe(serial_oe), .nine(nine),
    .bit_cyc(bit_cyc), .frm_vld(frm_vld), .frm(frm));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cmp(input string what, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    exp_rd.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  // Queue a frame and write the holding buffer
  task automatic send(input logic n9);
    d = 8'($urandom);
    exp_rx.push_back({1'b1, n9 & nine, d});
    wreg(`AST_OFF_HOLD, d);
  endtask
  task automatic wait_frames;
    for (int c = 0; exp_rx.size() != 0; c++) begin
      if (c > 30000) begin
        error_cnt++;
        tally_and_finish();
      end
      @(posedge mclk);
    end
    // Let the stop bit run out so the shifter is empty again
    repeat (bit_cyc) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Watcher: read data in the cycle after a read, frames as they arrive
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rd_q) cmp("rdata", {2'b00, exp_rd.pop_front()}, {2'b00, rdata});
    if (frm_vld) cmp("frame", exp_rx.size() ? exp_rx.pop_front() : 10'h3FF, frm);
    rd_q <= rd;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset, addr, wdata, wr, rd, sleep, nine, rd_q} = {1'b1, 16'h0000, 5'h00};
    bit_cyc = 16'h0010;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(97241));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rreg(`AST_OFF_TSC, `AST_TSC_RESET);
    rreg(`AST_OFF_DIVISOR, 8'h00);
    rreg(`AST_OFF_FLAGS, 8'h00);
    rreg(`AST_OFF_ENABLES, 8'h00);
    rreg(`AST_OFF_SERIAL_CTRL, 8'h00);
    rreg(8'h55, 8'h00);
    $display("test reset values done");
    // Rate, port, interrupt enable, then transmitter on
    div = 8'($urandom_range(2));
    wreg(`AST_OFF_DIVISOR, div);
    wreg(`AST_OFF_SERIAL_CTRL, 8'h80);
    wreg(`AST_OFF_ENABLES, 8'h10);
    wreg(`AST_OFF_TSC, 8'h24);
    bit_cyc = 16'(16 * (div + 1));
    rreg(`AST_OFF_FLAGS, 8'h10);
    wreg(`AST_OFF_FLAGS, 8'h00);
    rreg(`AST_OFF_FLAGS, 8'h10);
    @(negedge mclk) cmp("irq on", 10'h001, {9'h000, tx_irq});
    wreg(`AST_OFF_ENABLES, 8'h00);
    @(negedge mclk) cmp("irq masked", 10'h000, {9'h000, tx_irq});
    wreg(`AST_OFF_ENABLES, 8'h10);
    $display("test flags done");
    send(1'b0);
    send(1'b0);
    rreg(`AST_OFF_FLAGS, 8'h00);
    rreg(`AST_OFF_TSC, 8'h24);
    wait_frames();
    rreg(`AST_OFF_TSC, 8'h26);
    rreg(`AST_OFF_FLAGS, 8'h10);
    @(negedge mclk) cmp("idle line", 10'h003, {8'h00, serial_out, serial_oe});
    $display("test back to back done");
    // Ninth bit and both oversampling rates, ninth value before data
    nine = 1'b1;
    for (k = 0; k < 4; k++) begin
      bit_cyc = 16'((k[0] ? 16 : 64) * (div + 1));
      wreg(`AST_OFF_TSC, {5'b01100, k[0], 1'b0, k[1]});
      send(k[1]);
      wait_frames();
    end
    nine = 1'b0;
    bit_cyc = 16'(16 * (div + 1));
    wreg(`AST_OFF_TSC, 8'h24);
    $display("test ninth bit done");
    // Sleep, then clocked mode, must hold the character back
    for (k = 0; k < 2; k++) begin
      if (k == 0) sleep <= 1'b1;
      else wreg(`AST_OFF_TSC, 8'h34);
      repeat (3) @(posedge mclk);
      send(1'b0);
      repeat (300) @(posedge mclk);
      cmp("held", 10'h001, {9'h000, exp_rx.size() == 1});
      rreg(`AST_OFF_TSC, k ? 8'h36 : 8'h26);
      if (k == 0) sleep <= 1'b0;
      else wreg(`AST_OFF_TSC, 8'h24);
      wait_frames();
    end
    $display("test inhibit done");
    // Abort mid-character, then buffer first and enable afterwards
    wreg(`AST_OFF_HOLD, 8'($urandom));
    repeat (bit_cyc * 3) @(posedge mclk);
    wreg(`AST_OFF_TSC, 8'h04);
    @(negedge mclk) cmp("oe after abort", 10'h000, {9'h000, serial_oe});
    repeat (bit_cyc * 12) @(posedge mclk);
    rreg(`AST_OFF_TSC, 8'h06);
    send(1'b0);
    rreg(`AST_OFF_FLAGS, 8'h00);
    wreg(`AST_OFF_TSC, 8'h24);
    wait_frames();
    rreg(`AST_OFF_FLAGS, 8'h10);
    repeat (3) @(posedge mclk);
    $display("test abort done");
    tally_and_finish();
  end
endmodule // ast_tx_test
`default_nettype wire
